// File: hw/hwm_ctl_map.vh
/*
 Register map, field positions and reset values of the monitor
 identification and run-control register group.
 Assumes inclusion by bare name from the design files under hw/.
*/
`ifndef HWM_CTL_MAP_VH
`define HWM_CTL_MAP_VH

// Register addresses
`define HWM_ADDR_DUTY0 8'h30
`define HWM_ADDR_DUTY2 8'h32
`define HWM_ADDR_MAKER_ID 8'h3e
`define HWM_ADDR_SILICON_REV 8'h3f
`define HWM_ADDR_RUN_CTRL 8'h40
`define HWM_ADDR_PARAM_FIRST 8'h5c
`define HWM_ADDR_PARAM_LAST 8'h6e
`define HWM_PARAM_COUNT 19

// Control register fields
`define HWM_CTRL_START_BIT 0
`define HWM_CTRL_LOCK_BIT 1
`define HWM_CTRL_READY_BIT 2
`define HWM_CTRL_FORCE_BIT 3
`define HWM_CTRL_RESET 8'h00

// Revision register fields
`define HWM_REV_STEP_LSB 0
`define HWM_REV_BASE_LSB 4
`define HWM_REV_SUPERSET_BIT 3

// Duty values
`define HWM_DUTY_FULL 8'hff
`define HWM_DUTY_OFF 8'h00

`endif

// File: hw/hwm_ready_seq.v
/*
 Power-up ready sequencer: raises a sticky ready flag after a settle
 count once the converters report correct operation.
 Assumes adc_ok is synchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module hwm_ready_seq #(
   parameter SETTLE_CYCLES = 16
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire adc_ok,
   output reg ready_r
);

   reg [15:0] cnt_r;

   // Ready only after reset settle and converters healthy
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_r <= 16'h0000;
         ready_r <= 1'b0;
      end else begin
         if (cnt_r != SETTLE_CYCLES[15:0]) begin
            cnt_r <= cnt_r + 16'h0001;
         end else if (adc_ok) begin
            ready_r <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// File: hw/hwm_pwm_ch.v
/*
 One PWM output channel: 255-step period, advanced by a tick enable.
 Assumes tick is a one-cycle pulse from a divider in sys_clk domain.
*/
`timescale 1ns/100ps
`default_nettype none

module hwm_pwm_ch (
   input wire sys_clk,
   input wire sys_rst,
   input wire tick,
   input wire [7:0] duty,
   output reg pwm_r
);

   reg [7:0] cnt_r;

   // Counter 0..254, so duty ff gives a constant high
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_r <= 8'h00;
         pwm_r <= 1'b1;
      end else if (tick) begin
         cnt_r <= (cnt_r == 8'hfe) ? 8'h00 : cnt_r + 8'h01;
         pwm_r <= (cnt_r < duty);
      end
   end

endmodule

`default_nettype wire

// File: hw/hwm_ctl_top.v
/*
 Identification and run-control register group of a hardware monitor,
 reached over the two-wire management bus, with fan parameter store,
 lock, ready sequencing and PWM full-duty force.
 Assumes scl_i and sda_i synchronous to sys_clk; the bus wire is
 resolved outside from sda_oe_r (low driven when high).
*/
// Summary of operation
// - The maker identifier register returns a fixed code and ignores writes.
// - The revision register holds the stepping low and the base number high, both constant.
// - The top bit of the stepping field is set to flag the register superset.
// - The revision register is read-only and writes do not change it.
// - With start set, fan control uses the programmed parameters at 5Ch to 6Eh.
// - With start clear, fan control uses built-in defaults and ignores programmed values.
// - Setting or clearing start leaves the stored parameter values untouched.
// - The start bit stays writable whether or not lock is set.
// - Writing one to lock makes the parameter registers read-only until power-off.
// - Once lock is set the lock bit itself cannot be cleared.
// - Ready reads zero until power-up is done and the converters work, then sets.
// - While the force bit is one every PWM output runs at full duty, lock or not.
// - The force bit overrides a disabled channel, which also runs at full duty.
// - Before start the duty registers read ffh and outputs run full, after start they follow the algorithm.
`timescale 1ns/100ps
`default_nettype none
`include "hwm_ctl_map.vh"

module hwm_ctl_top #(
   parameter [6:0] SLAVE_ADDR = 7'h2e,
   parameter [7:0] MAKER_ID = 8'h5a,
   parameter [3:0] BASE_NUMBER = 4'h3,
   parameter [3:0] STEP_NUMBER = 4'h8,
   parameter [7:0] DEFAULT_PARAM = 8'h00,
   parameter READY_SETTLE = 16,
   parameter PWM_DIV = 8
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire scl_i,
   input wire sda_i,
   output reg sda_o_r,
   output reg sda_oe_r,
   input wire adc_ok,
   input wire [23:0] auto_duty,
   input wire [2:0] pwm_disable,
   input wire [4:0] prm_idx,
   output reg [7:0] prm_val_r,
   output reg use_programmed_r,
   output reg param_lock_r,
   output wire [2:0] pwm_out
);

   // Bus states
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_RX = 3'd1;
   localparam [2:0] ST_ACK = 3'd2;
   localparam [2:0] ST_TX = 3'd3;
   localparam [2:0] ST_TACK = 3'd4;

   // Byte phases of a transaction
   localparam [1:0] PH_ADDR = 2'd0;
   localparam [1:0] PH_PTR = 2'd1;
   localparam [1:0] PH_DATA = 2'd2;

   reg [2:0] state_r;
   reg [1:0] phase_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg [7:0] ptr_r;
   reg rd_r;
   reg scl_d_r;
   reg sda_d_r;
   reg start_r;
   reg lock_r;
   reg force_r;
   reg [7:0] param_mem [0:`HWM_PARAM_COUNT-1];
   reg [23:0] duty_r;
   reg [15:0] div_r;
   reg tick_r;
   wire ready;
   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire [7:0] ptr_off;
   wire [4:0] ptr_idx;
   integer i, j;

   assign scl_rise = scl_i & ~scl_d_r;
   assign scl_fall = ~scl_i & scl_d_r;
   assign bus_start = scl_i & scl_d_r & sda_d_r & ~sda_i;
   assign bus_stop = scl_i & scl_d_r & ~sda_d_r & sda_i;
   assign ptr_off = ptr_r - `HWM_ADDR_PARAM_FIRST;
   assign ptr_idx = ptr_off[4:0];

   // Address falls in the fan parameter range
   function is_param;
      input [7:0] a;
      begin
         is_param = (a >= `HWM_ADDR_PARAM_FIRST) && (a <= `HWM_ADDR_PARAM_LAST);
      end
   endfunction

   // Effective duty of one channel
   function [7:0] eff_duty;
      input [7:0] auto_val;
      input dis;
      input st;
      input frc;
      begin
         if (frc) begin
            eff_duty = `HWM_DUTY_FULL;
         end else if (!st) begin
            eff_duty = `HWM_DUTY_FULL;
         end else if (dis) begin
            eff_duty = `HWM_DUTY_OFF;
         end else begin
            eff_duty = auto_val;
         end
      end
   endfunction

   // Read data for an address
   function [7:0] rd_data;
      input [7:0] a;
      reg [7:0] off;
      begin
         off = a - `HWM_ADDR_PARAM_FIRST;
         if (a == `HWM_ADDR_MAKER_ID) begin
            rd_data = MAKER_ID;
         end else if (a == `HWM_ADDR_SILICON_REV) begin
            rd_data = {BASE_NUMBER, STEP_NUMBER};
            rd_data[`HWM_REV_SUPERSET_BIT] = 1'b1;
         end else if (a == `HWM_ADDR_RUN_CTRL) begin
            rd_data = 8'h00;
            rd_data[`HWM_CTRL_START_BIT] = start_r;
            rd_data[`HWM_CTRL_LOCK_BIT] = lock_r;
            rd_data[`HWM_CTRL_READY_BIT] = ready;
            rd_data[`HWM_CTRL_FORCE_BIT] = force_r;
         end else if (a >= `HWM_ADDR_DUTY0 && a <= `HWM_ADDR_DUTY2) begin
            rd_data = duty_r[(a[1:0] * 8) +: 8];
         end else if (is_param(a)) begin
            rd_data = param_mem[off[4:0]];
         end else begin
            rd_data = 8'h00;
         end
      end
   endfunction

   wire [7:0] rd_cur = rd_data(ptr_r);

   hwm_ready_seq #(
      .SETTLE_CYCLES(READY_SETTLE)
   ) u_hwm_ready_seq (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .adc_ok(adc_ok),
      .ready_r(ready)
   );

   // PWM tick divider
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         div_r <= 16'h0000;
         tick_r <= 1'b0;
      end else if (div_r == PWM_DIV[15:0] - 16'h0001) begin
         div_r <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         div_r <= div_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_pwm
         hwm_pwm_ch u_hwm_pwm_ch (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .tick(tick_r),
            .duty(duty_r[g*8 +: 8]),
            .pwm_r(pwm_out[g])
         );
      end
   endgenerate

   // Duty selection, parameter read-out and status outputs
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         duty_r <= {3{`HWM_DUTY_FULL}};
         prm_val_r <= DEFAULT_PARAM;
         use_programmed_r <= 1'b0;
         param_lock_r <= 1'b0;
      end else begin
         for (i = 0; i < 3; i = i + 1) begin
            duty_r[i*8 +: 8] <= eff_duty(auto_duty[i*8 +: 8], pwm_disable[i], start_r,
               force_r);
         end
         if (start_r && prm_idx < `HWM_PARAM_COUNT) begin
            prm_val_r <= param_mem[prm_idx];
         end else begin
            prm_val_r <= DEFAULT_PARAM;
         end
         use_programmed_r <= start_r;
         param_lock_r <= lock_r;
      end
   end

   // Parameter store, never touched by start
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         for (j = 0; j < `HWM_PARAM_COUNT; j = j + 1) begin
            param_mem[j] <= DEFAULT_PARAM;
         end
      end else if (state_r == ST_RX && scl_fall && bit_cnt_r == 4'd8 && phase_r == PH_DATA
         && is_param(ptr_r) && !lock_r) begin
         param_mem[ptr_idx] <= shift_r;
      end
   end

   // Control register; identifier and revision have no storage to write
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         start_r <= 1'b0;
         lock_r <= 1'b0;
         force_r <= 1'b0;
      end else if (state_r == ST_RX && scl_fall && bit_cnt_r == 4'd8 && phase_r == PH_DATA
         && ptr_r == `HWM_ADDR_RUN_CTRL) begin
         start_r <= shift_r[`HWM_CTRL_START_BIT];
         lock_r <= lock_r | shift_r[`HWM_CTRL_LOCK_BIT];
         force_r <= shift_r[`HWM_CTRL_FORCE_BIT];
      end
   end

   // Two-wire bus slave; writes to 3e and 3f fall through unused
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         phase_r <= PH_ADDR;
         bit_cnt_r <= 4'd0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         rd_r <= 1'b0;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         sda_o_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else begin
         scl_d_r <= scl_i;
         sda_d_r <= sda_i;
         if (bus_start) begin
            state_r <= ST_RX;
            phase_r <= PH_ADDR;
            bit_cnt_r <= 4'd0;
            sda_oe_r <= 1'b0;
         end else if (bus_stop) begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
         end else begin
            case (state_r)
               ST_RX: begin
                  if (scl_rise && bit_cnt_r != 4'd8) begin
                     shift_r <= {shift_r[6:0], sda_i};
                     bit_cnt_r <= bit_cnt_r + 4'd1;
                  end else if (scl_fall && bit_cnt_r == 4'd8) begin
                     if (phase_r == PH_ADDR) begin
                        if (shift_r[7:1] == SLAVE_ADDR) begin
                           rd_r <= shift_r[0];
                           sda_oe_r <= 1'b1;
                           state_r <= ST_ACK;
                        end else begin
                           state_r <= ST_IDLE;
                        end
                     end else begin
                        if (phase_r == PH_PTR) begin
                           ptr_r <= shift_r;
                        end
                        sda_oe_r <= 1'b1;
                        state_r <= ST_ACK;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_r <= 4'd0;
                     if (phase_r == PH_ADDR && rd_r) begin
                        shift_r <= rd_cur;
                        sda_oe_r <= ~rd_cur[7];
                        state_r <= ST_TX;
                     end else begin
                        sda_oe_r <= 1'b0;
                        phase_r <= (phase_r == PH_ADDR) ? PH_PTR : PH_DATA;
                        state_r <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     bit_cnt_r <= bit_cnt_r + 4'd1;
                  end else if (scl_fall) begin
                     if (bit_cnt_r == 4'd8) begin
                        sda_oe_r <= 1'b0;
                        state_r <= ST_TACK;
                     end else begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sda_oe_r <= ~shift_r[6];
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_rise) begin
                     if (sda_i) begin
                        state_r <= ST_IDLE;
                     end else begin
                        bit_cnt_r <= 4'd0;
                     end
                  end else if (scl_fall) begin
                     shift_r <= rd_cur;
                     sda_oe_r <= ~rd_cur[7];
                     state_r <= ST_TX;
                  end
               end
               default: begin
                  sda_oe_r <= 1'b0;
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// File: dv/hwm_ctl_sva.sv
/*
 Port assertions for the monitor identification and run-control group.
 Assumes binding to the ports of hwm_ctl_top, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module hwm_ctl_sva #(
   parameter [7:0] DEFAULT_PARAM = 8'h00
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire scl_i,
   input wire sda_o_r,
   input wire sda_oe_r,
   input wire [4:0] prm_idx,
   input wire [7:0] prm_val_r,
   input wire use_programmed_r,
   input wire param_lock_r,
   input wire [2:0] pwm_out
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   AST_RST_VALUES: assert property ($fell(sys_rst) |-> pwm_out == 3'b111 &&
      !use_programmed_r && !param_lock_r && prm_val_r == DEFAULT_PARAM)
      else $error("control outputs not at reset values");
   AST_LOCK_STICKY: assert property (param_lock_r |=> param_lock_r)
      else $error("lock cleared before power-off");
   AST_DEFAULT_PRM: assert property (!use_programmed_r [*2] |->
      prm_val_r == DEFAULT_PARAM)
      else $error("programmed parameter used while stopped");
   AST_PRESTART_FULL: assert property (!use_programmed_r [*4] |->
      pwm_out == 3'b111)
      else $error("outputs not at full duty before start");
   AST_LOCKED_STORE: assert property ((param_lock_r && use_programmed_r &&
      $stable(prm_idx)) [*3] |-> $stable(prm_val_r))
      else $error("locked parameter changed");
   AST_ACK_LOW_EDGE: assert property ($rose(sda_oe_r) |-> !scl_i && !sda_o_r)
      else $error("data pulled low while bus clock high");
   COV_LOCKED: cover property ($rose(param_lock_r));
endmodule

`default_nettype wire

// File: dv/hwm_ctl_bench.sv
/*
 Self-checking bench for hwm_ctl_top, bit-banging the two-wire bus.
 Assumes the data wire resolves to low while sda_oe_r is high.
*/
`timescale 1ns/100ps
`default_nettype none

module hwm_ctl_bench;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic scl = 1'b1;
   logic sda_drv = 1'b1;
   logic adc_ok = 1'b0;
   logic [23:0] auto_duty = 24'h402010;
   logic [2:0] pwm_disable = 3'b000;
   logic [4:0] prm_idx = 5'h00;
   logic sda_o_r, sda_oe_r, use_programmed_r, param_lock_r;
   logic [7:0] prm_val_r, rd_v;
   logic [2:0] pwm_out, acc;
   wire sda = sda_drv & ~sda_oe_r;
   int fail_count = 0;
   int tests_run = 0;
   int cyc_cnt = 0;

   always #10 sys_clk = ~sys_clk;

   hwm_ctl_top #(.PWM_DIV(1)) u_hwm_ctl_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .scl_i(scl), .sda_i(sda), .sda_o_r(sda_o_r), .sda_oe_r(sda_oe_r),
      .adc_ok(adc_ok), .auto_duty(auto_duty), .pwm_disable(pwm_disable),
      .prm_idx(prm_idx), .prm_val_r(prm_val_r), .use_programmed_r(use_programmed_r),
      .param_lock_r(param_lock_r), .pwm_out(pwm_out));

   task give_verdict;
      $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task bitx(input logic b, output logic r);
      sda_drv = b;
      cyc(4);
      scl = 1'b1;
      cyc(4);
      r = sda;
      cyc(4);
      scl = 1'b0;
      cyc(4);
   endtask

   task sta;
      sda_drv = 1'b1;
      cyc(4);
      scl = 1'b1;
      cyc(4);
      sda_drv = 1'b0;
      cyc(4);
      scl = 1'b0;
      cyc(4);
   endtask

   task sto;
      sda_drv = 1'b0;
      cyc(4);
      scl = 1'b1;
      cyc(4);
      sda_drv = 1'b1;
      cyc(4);
   endtask

   task tx(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, r);
      chk("ack", 8'h00, {7'h00, r});
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      sta;
      tx(8'h5c);
      tx(a);
      tx(d);
      sto;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic r;
      sta;
      tx(8'h5c);
      tx(a);
      sta;
      tx(8'h5d);
      for (int i = 7; i >= 0; i--)
         bitx(1'b1, rd_v[i]);
      bitx(1'b1, r);
      sto;
      chk(nm, e, rd_v);
   endtask

   task t_rst;
      chk("pwm_rst", 8'h07, {5'h00, pwm_out});
      chk("start_rst", 8'h00, {7'h00, use_programmed_r});
      chk("lock_rst", 8'h00, {7'h00, param_lock_r});
   endtask

   task t_nack;
      logic r;
      logic [7:0] d;
      d = 8'h5e;
      sta;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, r);
      chk("nack", 8'h01, {7'h00, r});
      sto;
   endtask

   task t_id;
      rd(8'h3e, 8'h5a, "maker_id");
      wr(8'h3e, 8'ha5);
      rd(8'h3e, 8'h5a, "maker_id_wr");
      rd(8'h3f, 8'h38, "revision");
      chk("superset", 8'h01, {7'h00, rd_v[3]});
      wr(8'h3f, 8'h00);
      rd(8'h3f, 8'h38, "revision_wr");
   endtask

   task t_ready;
      rd(8'h40, 8'h00, "ctrl_not_ready");
      adc_ok = 1'b1;
      cyc(20);
      rd(8'h40, 8'h04, "ctrl_ready");
      wr(8'h40, 8'hf4);
      rd(8'h40, 8'h04, "ctrl_reserved");
   endtask

   task t_run;
      wr(8'h5c, 8'ha5);
      wr(8'h6e, 8'h5b);
      rd(8'h30, 8'hff, "duty_prestart");
      chk("prm_default", 8'h00, prm_val_r);
      wr(8'h40, 8'h01);
      cyc(4);
      chk("start", 8'h01, {7'h00, use_programmed_r});
      chk("prm_programmed", 8'ha5, prm_val_r);
      prm_idx = 5'h12;
      cyc(2);
      chk("prm_last", 8'h5b, prm_val_r);
      prm_idx = 5'h00;
      rd(8'h6e, 8'h5b, "prm_last_rd");
      rd(8'h30, 8'h10, "duty_auto");
      wr(8'h40, 8'h00);
      cyc(4);
      chk("prm_stopped", 8'h00, prm_val_r);
      wr(8'h40, 8'h01);
      cyc(4);
      chk("prm_kept", 8'ha5, prm_val_r);
   endtask

   task t_force;
      pwm_disable = 3'b100;
      cyc(10);
      chk("pwm_disabled", 8'h00, {7'h00, pwm_out[2]});
      rd(8'h32, 8'h00, "duty_disabled");
      wr(8'h40, 8'h09);
      cyc(4);
      acc = 3'b111;
      repeat (300) begin
         cyc(1);
         acc = acc & pwm_out;
      end
      chk("pwm_force", 8'h07, {5'h00, acc});
      rd(8'h32, 8'hff, "duty_force");
      wr(8'h40, 8'h01);
   endtask

   task t_lock;
      wr(8'h40, 8'h03);
      cyc(4);
      chk("lock_set", 8'h01, {7'h00, param_lock_r});
      wr(8'h5c, 8'h3c);
      rd(8'h5c, 8'ha5, "prm_locked");
      chk("prm_locked_out", 8'ha5, prm_val_r);
      wr(8'h40, 8'h09);
      cyc(10);
      chk("lock_kept", 8'h01, {7'h00, param_lock_r});
      chk("pwm_force_lock", 8'h07, {5'h00, pwm_out});
      wr(8'h40, 8'h00);
      cyc(4);
      chk("start_unlocked", 8'h00, {7'h00, use_programmed_r});
      rd(8'h40, 8'h06, "ctrl_locked");
   endtask

   always @(posedge sys_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 40000) begin
         fail_count++;
         give_verdict;
      end
   end

   initial begin
      cyc(20);
      sys_rst = 1'b0;
      cyc(2);
      t_rst;
      t_id;
      t_nack;
      t_ready;
      t_run;
      t_force;
      t_lock;
      give_verdict;
   end
endmodule

bind hwm_ctl_top hwm_ctl_sva #(.DEFAULT_PARAM(DEFAULT_PARAM)) u_hwm_ctl_sva (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_i(scl_i), .sda_o_r(sda_o_r),
   .sda_oe_r(sda_oe_r), .prm_idx(prm_idx), .prm_val_r(prm_val_r),
   .use_programmed_r(use_programmed_r), .param_lock_r(param_lock_r), .pwm_out(pwm_out));

`default_nettype wire
